// ===== rtl/ctr_sync_timebase.sv
// counter input synchronisation, duplicate count prevention and timebases
// assumes Avalon-MM master on core_clk_i; counter pins are asynchronous
//
// Function
// - each detected rising gate edge stores pulses counted since the previous one.
// - without prevention gate is seen only at the next rising source edge.
// - with prevention source and gate resampled on 80 MHz timebase, gate edges always store.
// - with prevention each pin source pulse counts once however long it stays high.
// - count and output follow source, or the 80 MHz timebase with prevention.
// - 32-bit up/down count; gate and other inputs synchronised first.
// - 80 MHz mode for prevention, position measurement or 80 MHz source.
// - else internal mode for 20 MHz/100 kHz sources, external mode otherwise.
// - 80 MHz mode samples on rising source edge, counts on the next.
// - internal mode samples on falling edge, counts on following rising edge.
// - external mode samples on delayed source, counts on next undelayed rising edge.
// - 80 MHz timebase selectable as source, from onboard clock or external reference.
// - 20 MHz timebase divides the 80 MHz timebase and is selectable.
// - 100 kHz timebase divides the 20 MHz timebase by 200, selectable.
// - bus reads move buffered counts out through the buffer register.
//
// The address map and the Avalon-MM interface to the registers were decided locally.
`timescale 1ns/1ns
module ctr_sync_timebase
  import ctr_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic gate_pin_i,
  input wire logic source_pin_i,
  input wire logic up_down_pin_i,
  input wire logic ext_ref_pin_i,
  output logic ctr_out_o,
  output logic tb20_o,
  output logic tb100k_o
);

  ctrl_t ctrl_r;
  logic ack_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cnt_nxt;
  logic [CNT_W-1:0] buf_data_r;
  logic buf_valid_r;
  logic overrun_r;
  logic wr_since_cap_r;
  logic out_r;

  // synchronised pins
  logic gate_s;
  logic src_s;
  logic up_s;
  logic ref_s;

  in_sync3 u_sync_gate (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(gate_pin_i),
    .q_o(gate_s)
  );
  in_sync3 u_sync_src (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(source_pin_i),
    .q_o(src_s)
  );
  in_sync3 u_sync_up (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(up_down_pin_i),
    .q_o(up_s)
  );
  in_sync3 u_sync_ref (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .d_i(ext_ref_pin_i),
    .q_o(ref_s)
  );

  // timebases
  logic ref_prev_r;
  wire ref_rise = ref_s & ~ref_prev_r;
  // onboard timebase ticks every core cycle; the single clock is the limit
  wire tick80 = ctrl_r.ref_ext ? ref_rise : 1'b1;
  logic tb20_rise;
  logic tb20_fall;
  logic tb100k_rise;
  logic tb100k_fall;

  tb_divider #(.DIV(DIV20)) u_div20 (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .en_i(tick80),
    .rise_o(tb20_rise),
    .fall_o(tb20_fall)
  );
  tb_divider #(.DIV(DIV100K)) u_div100k (
    .core_clk_i(core_clk_i),
    .sys_rst_i(sys_rst_i),
    .en_i(tb20_rise),
    .rise_o(tb100k_rise),
    .fall_o(tb100k_fall)
  );
  assign tb20_o = tb20_rise;
  assign tb100k_o = tb100k_rise;

  // mode decode
  wire int_src = ctrl_r.src_sel == SRC_TB20 || ctrl_r.src_sel == SRC_TB100K;
  wire use_80 = ctrl_r.dcp_en | ctrl_r.meas_pos | (ctrl_r.src_sel == SRC_TB80);
  sync_mode_t mode;
  assign mode = use_80 ? MODE_80 : (int_src ? MODE_INT : MODE_EXT);
  wire dcp_act = ctrl_r.dcp_en;

  // source edges in the core domain
  logic src_prev_r;
  wire ext_rise = src_s & ~src_prev_r;
  wire ext_fall = ~src_s & src_prev_r;
  wire src_rise = ctrl_r.src_sel == SRC_PIN ? ext_rise :
                  ctrl_r.src_sel == SRC_TB80 ? tick80 :
                  ctrl_r.src_sel == SRC_TB20 ? tb20_rise : tb100k_rise;
  wire src_fall = ctrl_r.src_sel == SRC_PIN ? ext_fall :
                  ctrl_r.src_sel == SRC_TB80 ? tick80 :
                  ctrl_r.src_sel == SRC_TB20 ? tb20_fall : tb100k_fall;

  // delayed copy of the external source edge
  logic [SRC_DELAY_CYC-1:0] dly_r;
  wire dly_rise = dly_r[SRC_DELAY_CYC-1];

  // resampling on the 80 MHz timebase for duplicate count prevention
  logic dsrc_r;
  logic dgate_r;
  wire src_level = ctrl_r.src_sel == SRC_PIN ? src_s : src_rise;
  wire dcp_rise = tick80 & src_level & ~dsrc_r;
  wire dgate_edge = tick80 & gate_s & ~dgate_r;

  // sample and count strobes per mode
  wire samp_stb = mode == MODE_INT ? src_fall :
                  mode == MODE_EXT ? dly_rise : src_rise;
  wire cnt_stb = dcp_act ? dcp_rise : src_rise;
  logic gate_smp_r;
  logic gate_used_r;
  wire gate_new = gate_smp_r & ~gate_used_r;
  wire count_ev = ctrl_r.enable & cnt_stb;
  wire store_ev = ctrl_r.enable & ctrl_r.buffered &
                  (dcp_act ? dgate_edge : cnt_stb & gate_new);
  wire [CNT_W-1:0] step = up_s ? 32'h0000_0001 : 32'hffff_ffff;
  wire tc = count_ev && cnt_nxt == 32'h0000_0000;

  always_comb begin
    if (store_ev) begin
      cnt_nxt = count_ev ? step : 32'h0000_0000;
    end else if (count_ev) begin
      cnt_nxt = cnt_r + step;
    end else begin
      cnt_nxt = cnt_r;
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ref_prev_r <= 1'b0;
      src_prev_r <= 1'b0;
      dsrc_r <= 1'b0;
      dgate_r <= 1'b0;
      dly_r <= '0;
    end else begin
      ref_prev_r <= ref_s;
      src_prev_r <= src_s;
      dly_r <= SRC_DELAY_CYC'({dly_r, src_rise});
      if (tick80) begin
        dsrc_r <= src_level;
        dgate_r <= gate_s;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gate_smp_r <= 1'b0;
      gate_used_r <= 1'b0;
    end else begin
      if (samp_stb) begin
        gate_smp_r <= gate_s;
      end
      if (cnt_stb) begin
        gate_used_r <= gate_smp_r;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= '0;
      out_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      out_r <= ctrl_r.out_toggle ? out_r ^ tc : tc;
    end
  end
  assign ctr_out_o = out_r;

  // bus slave: one wait state, read data registered in the wait cycle
  wire req = avs_read | avs_write;
  wire accept = req & ack_r;
  wire capture = avs_read & ~ack_r;
  wire wr_ctrl = accept & avs_write & avs_address == ADDR_CTRL & avs_byteenable[0];
  wire wr_stat = accept & avs_write & avs_address == ADDR_STATUS & avs_byteenable[0];
  wire pop = accept & avs_read & avs_address == ADDR_BUF;
  wire [31:0] stat_word = {27'h0, out_r, mode, overrun_r, buf_valid_r};
  wire [31:0] rd_mux = avs_address == ADDR_CTRL ? {24'h0, ctrl_r} :
                       avs_address == ADDR_COUNT ? cnt_r :
                       avs_address == ADDR_BUF ? buf_data_r :
                       avs_address == ADDR_STATUS ? stat_word : 32'h0;
  assign avs_waitrequest = req & ~ack_r;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ack_r <= 1'b0;
      avs_readdata <= 32'h0;
      ctrl_r <= CTRL_RESET;
    end else begin
      ack_r <= req & ~ack_r;
      if (capture) begin
        avs_readdata <= rd_mux;
      end
      if (wr_ctrl) begin
        ctrl_r <= avs_writedata[7:0];
      end
    end
  end

  // buffer word: a new store wins over a pop or an overrun clear
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      buf_data_r <= '0;
      buf_valid_r <= 1'b0;
      overrun_r <= 1'b0;
      wr_since_cap_r <= 1'b0;
    end else begin
      if (store_ev) begin
        buf_data_r <= cnt_r;
        buf_valid_r <= 1'b1;
      end else if (pop && !wr_since_cap_r) begin
        buf_valid_r <= 1'b0;
      end
      if (store_ev && buf_valid_r && !pop) begin
        overrun_r <= 1'b1;
      end else if (wr_stat && avs_writedata[STAT_OVERRUN]) begin
        overrun_r <= 1'b0;
      end
      // a store after the read data was captured must not be popped unseen
      if (store_ev) begin
        wr_since_cap_r <= 1'b1;
      end else if (capture) begin
        wr_since_cap_r <= 1'b0;
      end
    end
  end

  // helper: tb20 ticks between 100 kHz ticks
  logic [7:0] gap_r;
  logic seen_r;
  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      gap_r <= 8'h00;
      seen_r <= 1'b0;
    end else if (tb100k_rise) begin
      gap_r <= 8'(tb20_rise);
      seen_r <= 1'b1;
    end else if (tb20_rise) begin
      gap_r <= gap_r + 8'h01;
    end
  end

  a_tb20_spacing: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tb20_rise |=> !tb20_rise [*3])
    else $error("20 MHz tick spaced under four timebase ticks");

  a_tb100k_ratio: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    tb100k_rise && seen_r |-> gap_r == DIV100K)
    else $error("100 kHz tick not every 200 tb20 ticks");

  a_mode_80: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    (ctrl_r.dcp_en || ctrl_r.meas_pos || ctrl_r.src_sel == SRC_TB80) |-> mode == MODE_80)
    else $error("80 MHz mode not selected");

  a_mode_other: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !use_80 |-> (mode == MODE_INT) == (ctrl_r.src_sel != SRC_PIN))
    else $error("internal or external mode wrong");

  a_store_value: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    store_ev |=> buf_valid_r && buf_data_r == $past(cnt_r))
    else $error("buffer missed the count");

  a_store_cause: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    store_ev && !dcp_act |-> cnt_stb && gate_smp_r && !gate_used_r)
    else $error("store without sampled gate edge");

  a_dcp_gate: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    dcp_act && ctrl_r.enable && ctrl_r.buffered && dgate_edge |-> store_ev)
    else $error("gate edge lost with prevention");

  a_dcp_once: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    dcp_act && tick80 && count_ev ##1 tick80 && $stable(ctrl_r) |-> !count_ev)
    else $error("long source pulse counted twice");

  a_int_order: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    mode == MODE_INT && samp_stb |-> src_fall)
    else $error("internal mode sampled off the falling edge");

  a_ext_delay: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    mode == MODE_EXT && src_rise ##1 mode == MODE_EXT |-> samp_stb)
    else $error("delayed source sample missing");

  a_count_step: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    count_ev && !store_ev |=> cnt_r == $past(cnt_r) + $past(step))
    else $error("count did not step once");

  a_bus_wait: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    req && !ack_r ##1 req |-> !avs_waitrequest)
    else $error("bus answer not after one wait state");

  a_overrun_set: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    store_ev && buf_valid_r && !pop |=> overrun_r)
    else $error("overrun not flagged on lost store");

  a_store_restart: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    store_ev && !count_ev |=> cnt_r == 32'h0000_0000)
    else $error("count did not restart at store");

  a_no_src_store: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !dcp_act && !cnt_stb |-> !store_ev)
    else $error("store without a source edge");

  a_disabled_hold: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !ctrl_r.enable |=> $stable(cnt_r))
    else $error("count moved while disabled");

  a_out_pulse: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    !ctrl_r.out_toggle && tc |=> ctr_out_o)
    else $error("terminal count pulse missing");

  a_out_toggle: assert property (@(posedge core_clk_i) disable iff (sys_rst_i)
    ctrl_r.out_toggle && tc |=> ctr_out_o != $past(ctr_out_o))
    else $error("terminal count toggle missing");

endmodule

// ===== rtl/in_sync3.sv
// three-stage synchroniser for one asynchronous pin
// output changes only once stages two and three agree
`timescale 1ns/1ns
module in_sync3 (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1_r <= d_i;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q_o <= s3_r;
      end
    end
  end
endmodule

// ===== rtl/tb_divider.sv
// enable-pulse divider: counts input ticks, flags rising and falling phase
// assumes en_i is a one-cycle pulse in the core clock domain
`timescale 1ns/1ns
module tb_divider #(
  parameter logic [7:0] DIV = 8'h04
) (
  input wire logic core_clk_i,
  input wire logic sys_rst_i,
  input wire logic en_i,
  output logic rise_o,
  output logic fall_o
);
  logic [7:0] cnt_r;
  wire last = (cnt_r == DIV - 8'h01);

  always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r <= 8'h00;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      rise_o <= en_i && cnt_r == 8'h00;
      fall_o <= en_i && cnt_r == (DIV >> 1);
      if (en_i) begin
        cnt_r <= last ? 8'h00 : cnt_r + 8'h01;
      end
    end
  end
endmodule

// ===== shared/ctr_pkg.sv
// constants, types and register map of the counter sync and timebase block
// assumes a 100 MHz core clock standing in for the 80 MHz timebase domain
package ctr_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int TB80_FREQ_KHZ = 80000;
  localparam int TB20_FREQ_KHZ = 20000;
  localparam int TB100K_FREQ_KHZ = 100;
  localparam logic [7:0] DIV20 = 8'(TB80_FREQ_KHZ / TB20_FREQ_KHZ);
  localparam logic [7:0] DIV100K = 8'(TB20_FREQ_KHZ / TB100K_FREQ_KHZ);
  localparam int SRC_DELAY_NS = 10;
  localparam int SRC_DELAY_CYC = (SRC_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  localparam int CNT_W = 32;

  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_COUNT = 4'h4;
  localparam logic [3:0] ADDR_BUF = 4'h8;
  localparam logic [3:0] ADDR_STATUS = 4'hc;

  typedef enum logic [1:0] {
    SRC_PIN = 2'b00,
    SRC_TB80 = 2'b01,
    SRC_TB20 = 2'b10,
    SRC_TB100K = 2'b11
  } src_sel_t;

  typedef enum logic [1:0] {
    MODE_80 = 2'b00,
    MODE_INT = 2'b01,
    MODE_EXT = 2'b10
  } sync_mode_t;

  // control register, bit 0 is enable
  typedef struct packed {
    logic ref_ext;
    logic out_toggle;
    logic buffered;
    src_sel_t src_sel;
    logic meas_pos;
    logic dcp_en;
    logic enable;
  } ctrl_t;

  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int STAT_VALID = 0;
  localparam int STAT_OVERRUN = 1;
  localparam int STAT_MODE = 2;
  localparam int STAT_OUT = 4;

endpackage

// ===== tb/ctr_sync_timebase_tb.sv
// self-checking bench for the counter sync and timebase block
// assumes the Avalon slave answers after one wait cycle, bounded here anyway
`timescale 1ns/1ns
module ctr_sync_timebase_tb;
  import ctr_pkg::*;
  logic core_clk_i, sys_rst_i, avs_read, avs_write, avs_waitrequest;
  logic [3:0] avs_address, avs_byteenable;
  logic [31:0] avs_writedata, avs_readdata, seed;
  logic gate, source, up_down_pin_i, ext_ref, ctr_out_o, tb20_o, tb100k_o, ref_run;
  int bad_count, samples_checked, out_seen;

  ctr_sync_timebase ctr_sync_timebase_i (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .gate_pin_i(gate), .source_pin_i(source), .up_down_pin_i(up_down_pin_i),
    .ext_ref_pin_i(ext_ref), .ctr_out_o(ctr_out_o), .tb20_o(tb20_o), .tb100k_o(tb100k_o));
  pin_partner pin_partner_i (.core_clk_i(core_clk_i), .ref_run_i(ref_run),
    .gate_o(gate), .source_o(source), .ext_ref_o(ext_ref));

  initial begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end
  always @(posedge core_clk_i) if (ctr_out_o === 1'b1) out_seen <= out_seen + 1;

  task automatic finish_test();
    if (bad_count == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic lim(input int k, input int bound);
    if (k >= bound) begin
      bad_count++;
      $display("BAD %0t wait bound used up", $time);
      finish_test();
    end
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [1:0] exp_mode(logic dcp, logic pos, logic [1:0] s);
    if (dcp || pos || s == SRC_TB80) return MODE_80;
    if (s == SRC_TB20 || s == SRC_TB100K) return MODE_INT;
    return MODE_EXT;
  endfunction
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int k;
    k = 0;
    @(posedge core_clk_i);
    avs_address <= a;
    avs_writedata <= wd;
    avs_write <= wr;
    avs_read <= ~wr;
    do begin
      @(posedge core_clk_i);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    lim(k, 50);
  endtask
  // waits for one timebase pulse, then counts cycles to the next
  task automatic gap(input bit big, output int cyc);
    int k;
    k = 0;
    cyc = 0;
    do begin
      @(posedge core_clk_i);
      k++;
    end while ((big ? tb100k_o : tb20_o) !== 1'b1 && k < 2000);
    do begin
      @(posedge core_clk_i);
      cyc++;
    end while ((big ? tb100k_o : tb20_o) !== 1'b1 && cyc < 2000);
    lim(k, 2000);
    lim(cyc, 2000);
  endtask

  initial begin
    repeat (60000) @(posedge core_clk_i);
    lim(1, 1);
  end

  initial begin
    logic [31:0] d;
    ctrl_t c;
    int n, m, g, o0, k;
    sys_rst_i = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hf;
    up_down_pin_i = 1'b1;
    ref_run = 1'b0;
    bad_count = 0;
    samples_checked = 0;
    out_seen = 0;
    seed = 32'd68060;
    repeat (10) @(posedge core_clk_i);
    sys_rst_i <= 1'b0;
    bus(0, ADDR_CTRL, 0, d);
    check_val(d, {24'h0, CTRL_RESET}, "ctrl reset");
    bus(0, ADDR_STATUS, 0, d);
    check_val(d, 32'(MODE_EXT) << STAT_MODE, "status reset");
    bus(1, 4'h2, rnd(), d);
    bus(0, 4'h2, 0, d);
    check_val(d, 32'h0, "unmapped read");
    bus(1, ADDR_COUNT, rnd(), d);
    bus(0, ADDR_COUNT, 0, d);
    check_val(d, 32'h0, "count is read only");
    for (int i = 0; i < 16; i++) begin
      c = '0;
      c.dcp_en = i[0];
      c.meas_pos = i[1];
      c.src_sel = src_sel_t'(i[3:2]);
      bus(1, ADDR_CTRL, {24'h0, c}, d);
      bus(0, ADDR_STATUS, 0, d);
      check_val(32'(d[STAT_MODE+:2]), 32'(exp_mode(i[0], i[1], i[3:2])), "mode");
    end
    c = '0;
    c.enable = 1'b1;
    c.dcp_en = 1'b1;
    c.buffered = 1'b1;
    bus(1, ADDR_CTRL, {24'h0, c}, d);
    n = 3 + int'(rnd() % 32'd10);
    m = int'(rnd() % 32'(n));
    // long high phases: each pulse must still count once
    pin_partner_i.pulses(n, 4 + int'(rnd() % 32'd32), 4 + int'(rnd() % 32'd8));
    repeat (6) @(posedge core_clk_i);
    bus(0, ADDR_COUNT, 0, d);
    check_val(d, 32'(n), "count up");
    up_down_pin_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    pin_partner_i.pulses(m, 4 + int'(rnd() % 32'd8), 4 + int'(rnd() % 32'd8));
    repeat (6) @(posedge core_clk_i);
    bus(0, ADDR_COUNT, 0, d);
    check_val(d, 32'(n - m), "count down");
    pin_partner_i.gate_pulse();
    bus(0, ADDR_STATUS, 0, d);
    check_val(32'(d[STAT_VALID]), 32'h1, "valid after store");
    bus(0, ADDR_BUF, 0, d);
    check_val(d, 32'(n - m), "stored count");
    bus(0, ADDR_STATUS, 0, d);
    check_val(32'(d[STAT_VALID]), 32'h0, "valid after pop");
    // second gate edge with no source pulse in between
    pin_partner_i.gate_pulse();
    bus(0, ADDR_BUF, 0, d);
    check_val(d, 32'h0, "store without source");
    up_down_pin_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    pin_partner_i.pulses(1, 5, 5);
    o0 = out_seen;
    up_down_pin_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    pin_partner_i.pulses(1, 5, 8);
    check_val(32'(out_seen - o0), 32'h1, "terminal count pulse");
    pin_partner_i.gate_pulse();
    pin_partner_i.gate_pulse();
    bus(0, ADDR_STATUS, 0, d);
    check_val(d, (32'h1 << STAT_OVERRUN) | (32'h1 << STAT_VALID), "overrun set");
    bus(1, ADDR_STATUS, 32'h1 << STAT_OVERRUN, d);
    bus(0, ADDR_STATUS, 0, d);
    check_val(d, 32'h1 << STAT_VALID, "overrun cleared");
    bus(0, ADDR_BUF, 0, d);
    check_val(d, 32'h0, "overrun stored count");
    c.out_toggle = 1'b1;
    bus(1, ADDR_CTRL, {24'h0, c}, d);
    up_down_pin_i <= 1'b1;
    repeat (6) @(posedge core_clk_i);
    pin_partner_i.pulses(1, 5, 5);
    up_down_pin_i <= 1'b0;
    repeat (6) @(posedge core_clk_i);
    pin_partner_i.pulses(1, 5, 8);
    check_val(32'(ctr_out_o), 32'h1, "toggle output");
    bus(0, ADDR_STATUS, 0, d);
    check_val(d, 32'h1 << STAT_OUT, "toggle in status");
    // no prevention, pin source: gate only seen through source edges
    c.out_toggle = 1'b0;
    c.dcp_en = 1'b0;
    bus(1, ADDR_CTRL, {24'h0, c}, d);
    up_down_pin_i <= 1'b1;
    k = 1 + int'(rnd() % 32'd6);
    repeat (6) @(posedge core_clk_i);
    pin_partner_i.pulses(k, 5, 5);
    pin_partner_i.gate_set(1'b1);
    repeat (6) @(posedge core_clk_i);
    bus(0, ADDR_STATUS, 0, d);
    check_val(d, 32'(MODE_EXT) << STAT_MODE, "no store before source");
    pin_partner_i.pulses(2, 5, 5);
    pin_partner_i.gate_set(1'b0);
    bus(0, ADDR_BUF, 0, d);
    check_val(d, 32'(k + 1), "store at source edge");
    bus(0, ADDR_COUNT, 0, d);
    check_val(d, 32'h1, "count restarts at store");
    gap(0, g);
    check_val(32'(g), 32'(DIV20), "tb20 spacing");
    gap(1, g);
    check_val(32'(g), 32'(DIV20) * 32'(DIV100K), "tb100k spacing");
    c.ref_ext = 1'b1;
    ref_run <= 1'b1;
    bus(1, ADDR_CTRL, {24'h0, c}, d);
    repeat (40) @(posedge core_clk_i);
    gap(0, g);
    check_val(32'(g), 32'h8 * 32'(DIV20), "tb20 from reference");
    finish_test();
  end
endmodule

// ===== tb/pin_partner.sv
// partner model: external signal source on the counter pins
// assumes its tasks are entered just after a rising edge of core_clk_i
`timescale 1ns/1ns
module pin_partner (
  input wire logic core_clk_i,
  input wire logic ref_run_i,
  output logic gate_o,
  output logic source_o,
  output logic ext_ref_o
);
  logic [1:0] ref_cnt_r;
  initial begin
    gate_o = 1'b0;
    source_o = 1'b0;
    ext_ref_o = 1'b0;
    ref_cnt_r = 2'h0;
  end
  // external reference: one rising edge every 8 cycles while running
  always @(posedge core_clk_i) begin
    ref_cnt_r <= ref_cnt_r + 2'h1;
    if (ref_run_i && ref_cnt_r == 2'h3) ext_ref_o <= ~ext_ref_o;
  end
  // callers keep hi and lo at 4 cycles or more, so 12.5 MHz or slower
  task automatic pulses(input int n, input int hi, input int lo);
    for (int i = 0; i < n; i++) begin
      source_o <= 1'b1;
      repeat (hi) @(posedge core_clk_i);
      source_o <= 1'b0;
      repeat (lo) @(posedge core_clk_i);
    end
  endtask
  task automatic gate_set(input logic v);
    gate_o <= v;
  endtask
  task automatic gate_pulse();
    gate_o <= 1'b1;
    repeat (8) @(posedge core_clk_i);
    gate_o <= 1'b0;
    repeat (8) @(posedge core_clk_i);
  endtask
endmodule
